// [verilog/tcp_top.sv]
// Channel 0 pin function select with AXI4-Lite register access
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module tcp_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [tcp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tcp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ch1_count_tick_i,
  input wire logic ch0_pin_a_i,
  output logic ch0_pin_a_o,
  output logic ch0_pin_a_oe_o,
  input wire logic ch0_pin_c_i,
  output logic ch0_pin_c_o,
  output logic ch0_pin_c_oe_o,
  output logic irq_o
);
  tcp_ch_if ch_a ();
  tcp_ch_if ch_c ();

  logic aw_hold_reg;
  logic [tcp_pkg::ADDR_W-1:0] aw_addr_reg;
  logic w_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [tcp_pkg::CTRL_W-1:0] ctrl_reg;
  logic [tcp_pkg::CNT_W-1:0] cnt_reg;
  logic [tcp_pkg::ST_W-1:0] status_reg;
  logic [tcp_pkg::ST_W-1:0] irq_en_reg;
  logic [tcp_pkg::ST_W-1:0] events;
  logic do_write;
  logic wr_ctrl;
  logic wr_cnt;
  logic wr_clear;
  logic wr_irq_en;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [31:0] ctrl_word;
  logic [31:0] cnt_word;
  logic [31:0] ctrl_merged;
  logic [31:0] cnt_merged;
  logic [31:0] gra_merged;
  logic [31:0] grc_merged;
  logic sel_wr_reg;

  // Merge a written word into an old one by byte strobes
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Zero-extend a counter-width value into a bus word
  function automatic logic [31:0] widen(input logic [tcp_pkg::CNT_W-1:0] v);
    return {{(32 - tcp_pkg::CNT_W){1'b0}}, v};
  endfunction

  // Write address and data may arrive in either order; each is held until both are in
  assign s_axi_awready = ce_i & ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready = ce_i & ~w_hold_reg & ~bvalid_reg;
  assign do_write = ce_i & aw_hold_reg & w_hold_reg & ~bvalid_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_reg <= 1'b0;
    end
  end

  // Write decode; unmapped or read-only offsets answer SLVERR
  assign wr_ctrl = do_write & (aw_addr_reg == tcp_pkg::OFF_CTRL);
  assign wr_cnt = do_write & (aw_addr_reg == tcp_pkg::OFF_CNT);
  assign wr_clear = do_write & (aw_addr_reg == tcp_pkg::OFF_CLEAR);
  assign wr_irq_en = do_write & (aw_addr_reg == tcp_pkg::OFF_IRQ_EN);
  assign ch_a.wr_en = do_write & (aw_addr_reg == tcp_pkg::OFF_GRA);
  assign ch_c.wr_en = do_write & (aw_addr_reg == tcp_pkg::OFF_GRC);
  assign wr_hit = wr_ctrl | wr_cnt | wr_clear | wr_irq_en | ch_a.wr_en | ch_c.wr_en;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= tcp_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? tcp_pkg::RESP_OKAY : tcp_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Strobed write words; slices are taken from these nets, never from a call
  assign ctrl_merged = merge_strb(ctrl_word, w_data_reg, w_strb_reg);
  assign cnt_merged = merge_strb(cnt_word, w_data_reg, w_strb_reg);
  assign gra_merged = merge_strb(widen(ch_a.gr), w_data_reg, w_strb_reg);
  assign grc_merged = merge_strb(widen(ch_c.gr), w_data_reg, w_strb_reg);

  // Control register: select fields, buffer flag, counter run
  assign ctrl_word = {{(32 - tcp_pkg::CTRL_W){1'b0}}, ctrl_reg};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= tcp_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= ctrl_merged[tcp_pkg::CTRL_W-1:0];
    end
  end

  // Select strobe lags the control write by one edge, so the units see the new field
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_wr_reg <= 1'b0;
    end else if (ce_i) begin
      sel_wr_reg <= wr_ctrl & w_strb_reg[0];
    end
  end

  // Channel 0 counter: free-running up count while enabled, loadable by software
  assign cnt_word = widen(cnt_reg);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= tcp_pkg::CNT_RST;
    end else if (wr_cnt) begin
      cnt_reg <= cnt_merged[tcp_pkg::CNT_W-1:0];
    end else if (ce_i && ctrl_reg[tcp_pkg::RUN_BIT]) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // Feed both units; select writes retrigger the initial pin level
  assign ch_a.sel = ctrl_reg[tcp_pkg::SEL_A_LSB +: 4];
  assign ch_c.sel = ctrl_reg[tcp_pkg::SEL_C_LSB +: 4];
  assign ch_a.sel_wr = sel_wr_reg;
  assign ch_c.sel_wr = sel_wr_reg;

  // Only C can serve as a buffer, so A is never silenced
  assign ch_a.inhibit = 1'b0;
  assign ch_c.inhibit = ctrl_reg[tcp_pkg::BUF_A_BIT];

  // Counter, run state and channel 1 activity fan out to both units
  assign ch_a.cnt = cnt_reg;
  assign ch_c.cnt = cnt_reg;
  assign ch_a.cnt_run = ctrl_reg[tcp_pkg::RUN_BIT];
  assign ch_c.cnt_run = ctrl_reg[tcp_pkg::RUN_BIT];
  assign ch_a.ch1_tick = ch1_count_tick_i;
  assign ch_c.ch1_tick = ch1_count_tick_i;
  assign ch_a.ce = ce_i;
  assign ch_c.ce = ce_i;
  assign ch_a.wr_data = gra_merged[tcp_pkg::CNT_W-1:0];
  assign ch_c.wr_data = grc_merged[tcp_pkg::CNT_W-1:0];

  // Raw pins; each unit synchronises its own before any logic reads it
  assign ch_a.pin_i = ch0_pin_a_i;
  assign ch_c.pin_i = ch0_pin_c_i;

  tcp_unit u_unit_a (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ch(ch_a)
  );

  tcp_unit u_unit_c (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ch(ch_c)
  );

  assign ch0_pin_a_o = ch_a.pin_o;
  assign ch0_pin_a_oe_o = ch_a.pin_oe;
  assign ch0_pin_c_o = ch_c.pin_o;
  assign ch0_pin_c_oe_o = ch_c.pin_oe;

  // Sticky status; a new event wins over a clear in the same cycle
  assign events = {ch_c.capture, ch_c.match, ch_a.capture, ch_a.match};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_reg <= tcp_pkg::ST_RST;
    end else if (ce_i) begin
      // Clear ignores byte strobes; every written one clears its bit
      if (wr_clear) begin
        status_reg <= (status_reg & ~w_data_reg[tcp_pkg::ST_W-1:0]) | events;
      end else begin
        status_reg <= status_reg | events;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_en_reg <= tcp_pkg::ST_RST;
    end else if (wr_irq_en && w_strb_reg[0]) begin
      irq_en_reg <= w_data_reg[tcp_pkg::ST_W-1:0];
    end
  end

  // Level interrupt straight from flops, no extra latency
  assign irq_o = |(status_reg & irq_en_reg);

  // Read decode; the clear register reads as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      tcp_pkg::OFF_CTRL: rd_word = ctrl_word;
      tcp_pkg::OFF_CNT: rd_word = cnt_word;
      tcp_pkg::OFF_GRA: rd_word = widen(ch_a.gr);
      tcp_pkg::OFF_GRC: rd_word = widen(ch_c.gr);
      tcp_pkg::OFF_STATUS: begin
        rd_word[tcp_pkg::ST_W-1:0] = status_reg;
        rd_word[tcp_pkg::ST_PIN_A] = ch_a.pin_o;
        rd_word[tcp_pkg::ST_PIN_C] = ch_c.pin_o;
      end
      tcp_pkg::OFF_CLEAR: rd_word = 32'h0000_0000;
      tcp_pkg::OFF_IRQ_EN: rd_word[tcp_pkg::ST_W-1:0] = irq_en_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // One read in flight; data held until the master takes it
  assign s_axi_arready = ce_i & ~rvalid_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= tcp_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= rd_hit ? tcp_pkg::RESP_OKAY : tcp_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
endmodule

// [verilog/tcp_pkg.sv]
// Shared constants for the channel 0 pin function select block
package tcp_pkg;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CNT = 8'h04;
  localparam logic [7:0] OFF_GRA = 8'h08;
  localparam logic [7:0] OFF_GRC = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_CLEAR = 8'h14;
  localparam logic [7:0] OFF_IRQ_EN = 8'h18;
  // Control register field positions
  localparam int SEL_A_LSB = 0;
  localparam int SEL_C_LSB = 4;
  localparam int BUF_A_BIT = 8;
  localparam int RUN_BIT = 9;
  localparam int CTRL_W = 10;
  // Select field bit positions
  localparam int SEL_ROLE_BIT = 3;
  localparam int SEL_LEVEL_BIT = 2;
  // Status bit positions
  localparam int ST_A_MATCH = 0;
  localparam int ST_A_CAPT = 1;
  localparam int ST_C_MATCH = 2;
  localparam int ST_C_CAPT = 3;
  localparam int ST_W = 4;
  localparam int ST_PIN_A = 8;
  localparam int ST_PIN_C = 9;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] GR_RST = 16'hFFFF;
  localparam logic [ST_W-1:0] ST_RST = 4'h0;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// [verilog/tcp_ch_if.sv]
// Carrier between the top and one general register unit
`timescale 1ns/1ps
interface tcp_ch_if;
  logic [3:0] sel;
  logic sel_wr;
  logic inhibit;
  logic [tcp_pkg::CNT_W-1:0] cnt;
  logic cnt_run;
  logic ch1_tick;
  logic ce;
  logic wr_en;
  logic [tcp_pkg::CNT_W-1:0] wr_data;
  logic pin_i;
  logic match;
  logic capture;
  logic pin_o;
  logic pin_oe;
  logic [tcp_pkg::CNT_W-1:0] gr;
  modport ctrl (
    output sel, sel_wr, inhibit, cnt, cnt_run, ch1_tick, ce, wr_en, wr_data, pin_i,
    input match, capture, pin_o, pin_oe, gr
  );
  modport unit (
    input sel, sel_wr, inhibit, cnt, cnt_run, ch1_tick, ce, wr_en, wr_data, pin_i,
    output match, capture, pin_o, pin_oe, gr
  );
endinterface

// [verilog/tcp_unit.sv]
// One general register with its compare or capture pin function
`timescale 1ns/1ps
module tcp_unit (
  input wire logic clk_i,
  input wire logic rst_n_i,
  tcp_ch_if.unit ch
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic pin_reg;
  logic [tcp_pkg::CNT_W-1:0] gr_reg;
  logic role;
  logic rise;
  logic fall;
  logic cap_src;

  // Two-stage synchroniser plus edge history; first stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else if (ch.ce) begin
      sync1_reg <= ch.pin_i;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign role = ch.sel[tcp_pkg::SEL_ROLE_BIT];
  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  // Capture source decode from the low three bits
  always_comb begin
    case (ch.sel[2:0])
      3'b000: cap_src = rise;
      3'b001: cap_src = fall;
      3'b010, 3'b011: cap_src = rise | fall;
      default: cap_src = ch.ch1_tick;
    endcase
  end

  // Inhibit silences both roles while this register is a buffer
  assign ch.capture = ch.ce & ~ch.inhibit & role & cap_src;
  assign ch.match = ch.ce & ~ch.inhibit & ~role & ch.cnt_run & (ch.cnt == gr_reg);

  // General register: capture beats a bus write in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gr_reg <= tcp_pkg::GR_RST;
    end else if (ch.capture) begin
      gr_reg <= ch.cnt;
    end else if (ch.ce && ch.wr_en) begin
      gr_reg <= ch.wr_data;
    end
  end

  // Pin level: initial level on select write, then the match action
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_reg <= 1'b0;
    end else if (ch.ce && ch.sel_wr && !role) begin
      pin_reg <= ch.sel[tcp_pkg::SEL_LEVEL_BIT];
    end else if (ch.match) begin
      case (ch.sel[1:0])
        2'b01: pin_reg <= 1'b0;
        2'b10: pin_reg <= 1'b1;
        2'b11: pin_reg <= ~pin_reg;
        default: pin_reg <= pin_reg;
      endcase
    end
  end

  assign ch.pin_o = pin_reg;
  assign ch.pin_oe = ~ch.inhibit & ~role & (ch.sel[1:0] != 2'b00);
  assign ch.gr = gr_reg;
endmodule

// [test/tcp_top_assertions.sv]
// Port-level checks for the channel 0 pin function select block
`timescale 1ns/1ps
module tcp_top_assertions (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ch0_pin_a_o,
  input wire logic ch0_pin_a_oe_o,
  input wire logic ch0_pin_c_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Answers stand until taken
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_ar_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_ce_off;
    !ce_i |-> !(s_axi_awready || s_axi_wready || s_axi_arready);
  endproperty
  property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  // Output enables follow the control register only, so they move with a write
  property p_oe_a;
    $changed(ch0_pin_a_oe_o) |-> s_axi_bvalid;
  endproperty
  property p_oe_c;
    $changed(ch0_pin_c_oe_o) |-> s_axi_bvalid;
  endproperty
  // An undriven pin keeps its level unless a select write presets it
  property p_pin_a;
    $changed(ch0_pin_a_o) |-> ch0_pin_a_oe_o || s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");
  a_ar_busy: assert property (p_ar_busy)
    else $error("read address taken while busy");
  a_ce_off: assert property (p_ce_off)
    else $error("ready while clock enable low");
  a_r_ans: assert property (p_r_ans)
    else $error("read answer late");
  a_oe_a: assert property (p_oe_a)
    else $error("pin A enable moved without a write");
  a_oe_c: assert property (p_oe_c)
    else $error("pin C enable moved without a write");
  a_pin_a: assert property (p_pin_a)
    else $error("undriven pin A level moved");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == tcp_pkg::RESP_SLVERR);
  c_pin_hi: cover property ($rose(ch0_pin_a_o) && ch0_pin_a_oe_o);
  c_oe_c_off: cover property ($fell(ch0_pin_c_oe_o));
endmodule

// [test/tcp_pin_model.sv]
// Board side of the two channel 0 pins
`timescale 1ns/1ps
module tcp_pin_model (
  input wire logic [1:0] lvl_i,
  input wire logic [1:0] dev_i,
  input wire logic [1:0] oe_i,
  output logic [1:0] pin_o
);
  // The board backs off while the block drives, so no contention is modelled
  assign pin_o = (oe_i & dev_i) | (~oe_i & lvl_i);
endmodule

// [test/tcp_top_bench.sv]
// Self-checking bench for the channel 0 pin function select block
`timescale 1ns/1ps
module tcp_top_bench;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ch1_count_tick_i = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, lvl = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o;
  logic ch0_pin_a_i, ch0_pin_a_o, ch0_pin_a_oe_o, ch0_pin_c_i, ch0_pin_c_o, ch0_pin_c_oe_o;
  int failures = 0, cmp_count = 0, cyc = 0;
  tcp_top dut_u (.*);
  tcp_pin_model pin_u (.lvl_i(lvl), .dev_i({ch0_pin_c_o, ch0_pin_a_o}),
    .oe_i({ch0_pin_c_oe_o, ch0_pin_a_oe_o}), .pin_o({ch0_pin_c_i, ch0_pin_a_i}));
  always #2.5 clk_i = ~clk_i;
  // Watchdog; the sequence needs under two thousand cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Write with address and data offered together; bready raised late on purpose
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = tcp_pkg::RESP_OKAY);
    logic pa, pw, ta, tw;
    logic [1:0] r;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge clk_i);
      ta = s_axi_awready;
      tw = s_axi_wready;
      @(posedge clk_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do @(negedge clk_i); while (!s_axi_bvalid);
    @(posedge clk_i);
    s_axi_bready <= 1'b1;
    @(negedge clk_i);
    r = s_axi_bresp;
    @(posedge clk_i);
    s_axi_bready <= 1'b0;
    chk("bresp", er, r);
  endtask
  // Read and compare the masked word
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er = tcp_pkg::RESP_OKAY);
    logic t;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    t = 1'b0;
    while (!t) begin
      @(negedge clk_i);
      t = s_axi_arready;
      @(posedge clk_i);
    end
    s_axi_arvalid <= 1'b0;
    do @(negedge clk_i); while (!s_axi_rvalid);
    @(posedge clk_i);
    s_axi_rready <= 1'b1;
    @(negedge clk_i);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk_i);
    s_axi_rready <= 1'b0;
    chk("rdata", e, d & m);
    chk("rresp", er, r);
  endtask
  // Board level change, then time for the two sync flops and edge history
  task automatic drive(input int u, input logic v);
    @(posedge clk_i);
    lvl[u] <= v;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic wirq(input logic [7:0] a, input logic [31:0] d, input logic e);
    wr(a, d);
    @(negedge clk_i);
    chk("irq", e, irq_o);
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    chk("oe", 2'h0, {ch0_pin_c_oe_o, ch0_pin_a_oe_o});
    rd(tcp_pkg::OFF_GRA, 32'hFFFF_FFFF, 32'h0000_FFFF);
    // Every compare code on both registers; match at count 5
    for (int u = 0; u < 2; u++) begin
      for (int k = 0; k < 8; k++) begin
        wr(tcp_pkg::OFF_CTRL, k << (4 * u));
        wr(tcp_pkg::OFF_CNT, 32'h0000_0000);
        wr(tcp_pkg::OFF_GRA + 8'(4 * u), 32'h0000_0005);
        wr(tcp_pkg::OFF_CLEAR, 32'h0000_000F);
        @(negedge clk_i);
        chk("oe", k % 4 != 0, u ? ch0_pin_c_oe_o : ch0_pin_a_oe_o);
        if (k % 4 != 0) chk("init", k / 4, u ? ch0_pin_c_o : ch0_pin_a_o);
        wr(tcp_pkg::OFF_CTRL, (k << (4 * u)) | 32'h0000_0200);
        repeat (12) @(negedge clk_i);
        if (k % 4 != 0) chk("pin", k % 4 == 1 ? 0 : k % 4 == 2 ? 1 : 1 - k / 4,
          u ? ch0_pin_c_o : ch0_pin_a_o);
        rd(tcp_pkg::OFF_STATUS, 1 << (2 * u), 1 << (2 * u));
      end
    end
    // Edge and channel 1 tick coding of both capture registers against a frozen counter
    for (int u = 0; u < 2; u++) begin
      for (int k = 8; k < 13; k++) begin
        wr(tcp_pkg::OFF_CTRL, k << (4 * u));
        wr(tcp_pkg::OFF_CNT, 32'h0000_0100 + k);
        wr(tcp_pkg::OFF_CLEAR, 32'h0000_000F);
        drive(u, 1'b1);
        rd(tcp_pkg::OFF_STATUS, 2 << 2 * u, k != 9 && k != 12 ? 2 << 2 * u : 0);
        wr(tcp_pkg::OFF_CLEAR, 32'h0000_000F);
        drive(u, 1'b0);
        rd(tcp_pkg::OFF_STATUS, 2 << 2 * u, k > 8 && k < 12 ? 2 << 2 * u : 0);
        wr(tcp_pkg::OFF_CLEAR, 32'h0000_000F);
        ch1_count_tick_i <= 1'b1;
        @(posedge clk_i);
        ch1_count_tick_i <= 1'b0;
        rd(tcp_pkg::OFF_STATUS, 2 << 2 * u, k == 12 ? 2 << 2 * u : 0);
        rd(tcp_pkg::OFF_GRA + 8'(4 * u), 32'h0000_FFFF, 32'h0000_0100 + k);
      end
    end
    // C silenced while it buffers A
    wr(tcp_pkg::OFF_CTRL, 32'h0000_0180);
    wr(tcp_pkg::OFF_CLEAR, 32'h0000_000F);
    drive(1, 1'b1);
    rd(tcp_pkg::OFF_STATUS, 32'h0000_0008, 32'h0000_0000);
    wr(tcp_pkg::OFF_CTRL, 32'h0000_0120);
    @(negedge clk_i);
    chk("oe_c", 1'b0, ch0_pin_c_oe_o);
    // Interrupt raised, masked, unmasked and cleared
    wr(tcp_pkg::OFF_CTRL, 32'h0000_0008);
    wr(tcp_pkg::OFF_CLEAR, 32'h0000_000F);
    wirq(tcp_pkg::OFF_IRQ_EN, 32'h0000_0002, 1'b0);
    drive(0, 1'b1);
    @(negedge clk_i);
    chk("irq", 1'b1, irq_o);
    wirq(tcp_pkg::OFF_IRQ_EN, 32'h0000_0000, 1'b0);
    wirq(tcp_pkg::OFF_IRQ_EN, 32'h0000_0002, 1'b1);
    wirq(tcp_pkg::OFF_CLEAR, 32'h0000_0002, 1'b0);
    // Refused places and a short clock enable stall
    wr(tcp_pkg::OFF_STATUS, 32'h0000_0001, tcp_pkg::RESP_SLVERR);
    wr(8'h1C, 32'h0000_0000, tcp_pkg::RESP_SLVERR);
    rd(8'h1C, 32'h0000_0000, 32'h0000_0000, tcp_pkg::RESP_SLVERR);
    rd(tcp_pkg::OFF_CLEAR, 32'hFFFF_FFFF, 32'h0000_0000);
    ce_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
    rd(tcp_pkg::OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0008);
    tally_and_finish();
  end
endmodule
bind tcp_top tcp_top_assertions chk_u (.*);
